//--- hdl/rtoid_map.vh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the radio timing output block. Assumes a 16-bit word-addressed
 * register port; offsets are halfword indices.
 */
`ifndef RTOID_MAP_VH
`define RTOID_MAP_VH

`define RTOID_CLK_HZ        20000000
`define RTOID_STEP_NS       1000
`define RTOID_CLK_NS        50
`define RTOID_STEP_CYCLES   (`RTOID_STEP_NS / `RTOID_CLK_NS)
`define RTOID_STEP_LAST     5'h13

`define RTOID_NUM_OUT       5
`define RTOID_PID_FIRST     7'h37
`define RTOID_PID_LAST      7'h3b

`define RTOID_ADDR_W        8
`define RTOID_DATA_W        16

// Per-output registers: base plus 4 times output index.
`define RTOID_OFS_CTRL      8'h00
`define RTOID_OFS_ON        8'h01
`define RTOID_OFS_OFF       8'h02
`define RTOID_OUT_STRIDE    8'h04
`define RTOID_OFS_PAIR_A    8'h20
`define RTOID_OFS_PAIR_B    8'h21
`define RTOID_OFS_STATUS    8'h22
`define RTOID_OFS_MASK      8'h23
`define RTOID_OFS_LEVEL     8'h24
`define RTOID_OFS_PIN_SEL   8'h25

// Control register fields.
`define RTOID_CTRL_EN       0
`define RTOID_CTRL_SRC_RX   1
`define RTOID_CTRL_INV      2

// Status bits: one per output, set on each assertion edge.
`define RTOID_STATUS_W      5
`define RTOID_RESET_16      16'h0000

`endif

//--- hdl/rtoid_edge_timer.v
/*
 * One radio timing output: a window-edge delay timer counting whole
 * microseconds. Assumes the window input is already synchronised and the
 * microsecond tick is one clock long.
 */
`include "rtoid_map.vh"

module rtoid_edge_timer (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        enable_i,
    input  wire        us_tick_i,
    input  wire        win_i,
    input  wire        win_prev_i,
    input  wire [2:0]  ctrl_i,
    input  wire [15:0] on_delay_i,
    input  wire [15:0] off_delay_i,
    output reg         out_o,
    output wire        rise_o
);

    // ====================================================================
    // Edge-relative delay counters
    // ====================================================================
    reg        on_run;
    reg        off_run;
    reg [15:0] on_cnt;
    reg [15:0] off_cnt;
    reg        level;

    wire active = ctrl_i[`RTOID_CTRL_EN];
    wire rise   = win_i & ~win_prev_i;
    wire fall   = ~win_i & win_prev_i;
    wire on_hit  = on_run & (on_cnt == on_delay_i);
    wire off_hit = off_run & (off_cnt == off_delay_i);

    assign rise_o = enable_i & active & ~rise & on_hit & ~level;

    // A fresh edge restarts only its own counter; a fall does not cancel a
    // pending on delay, so a short window can still raise the output late.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_run  <= 1'b0;
            off_run <= 1'b0;
            on_cnt  <= 16'h0000;
            off_cnt <= 16'h0000;
            level   <= 1'b0;
        end else if (enable_i) begin
            if (!active) begin
                on_run  <= 1'b0;
                off_run <= 1'b0;
                level   <= 1'b0;
            end else begin
                if (rise) begin
                    on_run <= 1'b1;
                    on_cnt <= 16'h0000;
                end else if (on_hit) begin
                    on_run <= 1'b0;
                    level  <= 1'b1;
                end else if (on_run && us_tick_i) begin
                    on_cnt <= on_cnt + 16'h0001;
                end
                if (fall) begin
                    off_run <= 1'b1;
                    off_cnt <= 16'h0000;
                end else if (off_hit) begin
                    off_run <= 1'b0;
                    level   <= 1'b0;
                end else if (off_run && us_tick_i) begin
                    off_cnt <= off_cnt + 16'h0001;
                end
            end
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_o <= 1'b0;
        end else if (enable_i) begin
            out_o <= level ^ ctrl_i[`RTOID_CTRL_INV];
        end
    end

endmodule

//--- hdl/rtoid_top.v
/*
 * Radio timing outputs with diagnostic interrupt selection: five timers
 * timed from the transmit and receive window edges, a pin function
 * matcher and four word/bit selectors feeding the diagnostic interrupt.
 * Assumes a single 20 MHz clock, a 16-bit register port driven by logic
 * on the same clock, and window and diagnostic inputs from another domain.
 */
// What this block does
// - Five independent programmable timing outputs.
// - Timing outputs step in one microsecond units.
// - Pin function ids 55 to 59 select outputs.
// - Delays count from window rising and falling edges.
// - Interrupt sources: two MAC, two radio signals.
// - Word/bit select picks MAC bit or window/timer.
// - Four identical select pairs in two registers.
// - Timers 21 to 26 trigger radio events.
`include "rtoid_map.vh"

module rtoid_top (
    input  wire        clock_i,
    input  wire        reset_n_i,
    input  wire        clk_en_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [15:0] reg_rdata_o,
    input  wire        tx_window_i,
    input  wire        rx_window_i,
    input  wire [7:0]  mac_diag_i,
    input  wire [6:0]  pin_function_id_i,
    output wire [4:0]  radio_timing_output_o,
    output reg  [5:0]  radio_timer_o,
    output reg         pin_timing_o,
    output reg         radio_diag_interrupt_o,
    output reg         irq_o
);

    // ====================================================================
    // Reset release and input synchronisers
    // ====================================================================
    reg        rst_meta;
    reg        rst_n;
    reg [9:0]  sync_meta;
    reg [9:0]  sync_q;
    reg        tx_prev;
    reg        rx_prev;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // The first stage feeds only the second; edges are taken afterwards.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= 10'h000;
            sync_q    <= 10'h000;
            tx_prev   <= 1'b0;
            rx_prev   <= 1'b0;
        end else if (clk_en_i) begin
            sync_meta <= {mac_diag_i, rx_window_i, tx_window_i};
            sync_q    <= sync_meta;
            tx_prev   <= sync_q[0];
            rx_prev   <= sync_q[1];
        end
    end

    wire       tx_win   = sync_q[0];
    wire       rx_win   = sync_q[1];
    wire [7:0] mac_diag = sync_q[9:2];

    // ====================================================================
    // Microsecond tick
    // ====================================================================
    // The tick runs free, so the first step after a window edge may be
    // short; every delay resolves to whole microseconds, not below.
    reg [4:0] us_div;
    wire      us_tick = (us_div == `RTOID_STEP_LAST);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            us_div <= 5'h00;
        end else if (clk_en_i) begin
            us_div <= us_tick ? 5'h00 : us_div + 5'h01;
        end
    end

    // ====================================================================
    // Register storage
    // ====================================================================
    reg [2:0]  out_ctrl [0:4];
    reg [15:0] on_delay [0:4];
    reg [15:0] off_delay [0:4];
    reg [15:0] pair_a;
    reg [15:0] pair_b;
    reg [4:0]  status;
    reg [4:0]  mask;
    wire [4:0] rise_ev;

    // Decodes an output register address into its output index, or 7.
    function [2:0] out_index;
        input [7:0] addr;
        begin
            if (addr < 8'h14) begin
                out_index = addr[4:2];
            end else begin
                out_index = 3'h7;
            end
        end
    endfunction

    // Field offset inside an output's group.
    function [1:0] out_field;
        input [7:0] addr;
        begin
            out_field = addr[1:0];
        end
    endfunction

    // Matches one of the single registers outside the output groups.
    function is_reg;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // Chooses the window that an output is timed from.
    function win_pick;
        input sel_rx;
        input tx;
        input rx;
        begin
            win_pick = sel_rx ? rx : tx;
        end
    endfunction

    wire [2:0] w_idx = out_index(reg_addr_i);
    wire [1:0] w_fld = out_field(reg_addr_i);
    integer    k;

    // The port is halfword-wide, so every access is a whole 16-bit word;
    // byte lanes do not exist here.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < `RTOID_NUM_OUT; k = k + 1) begin
                out_ctrl[k]  <= 3'h0;
                on_delay[k]  <= `RTOID_RESET_16;
                off_delay[k] <= `RTOID_RESET_16;
            end
        end else if (clk_en_i && reg_write_i) begin
            if (w_idx != 3'h7) begin
                case (w_fld)
                    2'h0: out_ctrl[w_idx]  <= reg_wdata_i[2:0];
                    2'h1: on_delay[w_idx]  <= reg_wdata_i;
                    2'h2: off_delay[w_idx] <= reg_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    // The single registers sit in a process of their own, apart from the
    // arrays of the output groups.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pair_a <= `RTOID_RESET_16;
            pair_b <= `RTOID_RESET_16;
            mask   <= 5'h00;
        end else if (clk_en_i && reg_write_i) begin
            if (is_reg(reg_addr_i, `RTOID_OFS_PAIR_A)) begin
                pair_a <= reg_wdata_i;
            end
            if (is_reg(reg_addr_i, `RTOID_OFS_PAIR_B)) begin
                pair_b <= reg_wdata_i;
            end
            if (is_reg(reg_addr_i, `RTOID_OFS_MASK)) begin
                mask <= reg_wdata_i[4:0];
            end
        end
    end

    // Set wins over a write-one-to-clear in the same cycle.
    wire       st_clr = clk_en_i & reg_write_i
                      & is_reg(reg_addr_i, `RTOID_OFS_STATUS);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            status <= 5'h00;
        end else if (clk_en_i) begin
            status <= (status & ~(st_clr ? reg_wdata_i[4:0] : 5'h00))
                    | rise_ev;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= |(status & mask);
        end
    end

    // ====================================================================
    // Timing outputs
    // ====================================================================
    wire [4:0] timer_out;

    // Window and history switch together, so changing an output's source
    // cannot fake an edge.
    genvar g;
    generate
        for (g = 0; g < `RTOID_NUM_OUT; g = g + 1) begin : gen_out
            wire sel_rx = out_ctrl[g][`RTOID_CTRL_SRC_RX];
            rtoid_edge_timer u_timer (
                .clock_i     (clock_i),
                .rst_n_i     (rst_n),
                .enable_i    (clk_en_i),
                .us_tick_i   (us_tick),
                .win_i       (win_pick(sel_rx, tx_win, rx_win)),
                .win_prev_i  (win_pick(sel_rx, tx_prev, rx_prev)),
                .ctrl_i      (out_ctrl[g]),
                .on_delay_i  (on_delay[g]),
                .off_delay_i (off_delay[g]),
                .out_o       (timer_out[g]),
                .rise_o      (rise_ev[g])
            );
        end
    endgenerate

    assign radio_timing_output_o = timer_out;

    // Timers 21 to 26 form a six-bit vector toward the radio; the sixth
    // is the inverse of the first since only five generators exist.
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            radio_timer_o <= 6'h00;
        end else if (clk_en_i) begin
            radio_timer_o <= {~timer_out[0], timer_out};
        end
    end

    // ====================================================================
    // Pin function matching
    // ====================================================================
    wire [6:0] pid_off = pin_function_id_i - `RTOID_PID_FIRST;
    wire       pid_hit = (pin_function_id_i >= `RTOID_PID_FIRST)
                       && (pin_function_id_i <= `RTOID_PID_LAST);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_timing_o <= 1'b0;
        end else if (clk_en_i) begin
            pin_timing_o <= pid_hit & timer_out[pid_off[2:0]];
        end
    end

    // ====================================================================
    // Diagnostic interrupt selection
    // ====================================================================
    // Picks one source for a word/bit pair: low words read MAC bits, high
    // words read the windows and the radio timers.
    function diag_pick;
        input [1:0] wsel;
        input [2:0] bsel;
        input [7:0] mac;
        input [7:0] radio;
        begin
            if (!wsel[1]) begin
                diag_pick = mac[bsel];
            end else begin
                diag_pick = radio[bsel];
            end
        end
    endfunction

    // Source byte for the high words: transmit window on bit 7, receive
    // window on bit 6, timers 26 down to 21 on bits 5 to 0.
    wire [7:0] radio_src = {tx_win, rx_win, radio_timer_o};
    wire [3:0] pick;

    // Each pair is word select in [4:3] and bit select in [2:0] of a byte.
    assign pick[0] = diag_pick(pair_a[4:3], pair_a[2:0],
                               mac_diag, radio_src);
    assign pick[1] = diag_pick(pair_a[12:11], pair_a[10:8],
                               mac_diag, radio_src);
    assign pick[2] = diag_pick(pair_b[4:3], pair_b[2:0],
                               mac_diag, radio_src);
    assign pick[3] = diag_pick(pair_b[12:11], pair_b[10:8],
                               mac_diag, radio_src);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            radio_diag_interrupt_o <= 1'b0;
        end else if (clk_en_i) begin
            radio_diag_interrupt_o <= |pick;
        end
    end

    // ====================================================================
    // Register read port
    // ====================================================================
    reg [15:0] next_rdata;
    wire [2:0] r_idx = out_index(reg_addr_i);
    wire [1:0] r_fld = out_field(reg_addr_i);

    always @* begin
        next_rdata = 16'h0000;
        if (r_idx != 3'h7) begin
            case (r_fld)
                2'h0: next_rdata = {13'h0000, out_ctrl[r_idx]};
                2'h1: next_rdata = on_delay[r_idx];
                2'h2: next_rdata = off_delay[r_idx];
                default: next_rdata = 16'h0000;
            endcase
        end else begin
            case (reg_addr_i)
                `RTOID_OFS_PAIR_A: next_rdata = pair_a;
                `RTOID_OFS_PAIR_B: next_rdata = pair_b;
                `RTOID_OFS_STATUS: next_rdata = {11'h000, status};
                `RTOID_OFS_MASK:   next_rdata = {11'h000, mask};
                `RTOID_OFS_LEVEL:  next_rdata = {7'h00, pick, timer_out};
                default:           next_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else if (clk_en_i) begin
            reg_rdata_o <= reg_read_i ? next_rdata : 16'h0000;
        end
    end

endmodule

//--- test/rtoid_monitor.sv
/*
 * Port checks for the radio timing output block.
 * Assumes one clock and is attached to rtoid_top by bind.
 */
`include "rtoid_map.vh"

module rtoid_monitor (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        clk_en_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        tx_window_i,
    input wire logic        rx_window_i,
    input wire logic [7:0]  mac_diag_i,
    input wire logic [6:0]  pin_function_id_i,
    input wire logic [4:0]  radio_timing_output_o,
    input wire logic [5:0]  radio_timer_o,
    input wire logic        pin_timing_o,
    input wire logic        radio_diag_interrupt_o,
    input wire logic        irq_o
);
    // ==========================================================
    // Helper logic
    logic [2:0] run_cnt;
    logic [3:0] quiet_cnt;
    logic [3:0] evt_age;
    logic       settled;
    logic       pin_pick;
    logic [6:0] pin_idx;

    // The internal reset copy lags the pin, so checks wait a few edges.
    assign settled = (run_cnt == 3'h5);
    assign pin_idx = pin_function_id_i - `RTOID_PID_FIRST;
    assign pin_pick = (pin_function_id_i >= `RTOID_PID_FIRST &&
                       pin_function_id_i <= `RTOID_PID_LAST) ?
                      radio_timing_output_o[pin_idx[2:0]] : 1'b0;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_cnt <= 3'h0;
            quiet_cnt <= 4'h0;
            evt_age <= 4'hf;
        end else begin
            if (!settled)
                run_cnt <= run_cnt + 3'h1;
            if (reg_write_i || !$stable({mac_diag_i, tx_window_i,
                                         rx_window_i, radio_timer_o}))
                quiet_cnt <= 4'h0;
            else if (quiet_cnt != 4'hf)
                quiet_cnt <= quiet_cnt + 4'h1;
            if ((reg_write_i && clk_en_i) ||
                |(radio_timing_output_o & ~$past(radio_timing_output_o)))
                evt_age <= 4'h0;
            else if (evt_age != 4'hf)
                evt_age <= evt_age + 4'h1;
        end
    end

    // ==========================================================
    // Assertions
    default clocking mon_cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_read;
        settled && reg_read_i && clk_en_i;
    endsequence
    sequence s_idle;
        !reg_read_i && clk_en_i;
    endsequence

    a_rdata_cause: assert property (
        settled && $past(clk_en_i) && reg_rdata_o != 16'h0000
        |-> $past(reg_read_i)) else $error("read data without read");
    a_rdata_release: assert property (
        s_read ##1 s_idle |=> reg_rdata_o == 16'h0000)
        else $error("read data held too long");
    a_timer_mirror: assert property (
        settled && $past(clk_en_i) |-> radio_timer_o ==
        {~$past(radio_timing_output_o[0]), $past(radio_timing_output_o)})
        else $error("radio timers differ from outputs");
    a_pin_follow: assert property (
        settled && $past(clk_en_i) |-> pin_timing_o == $past(pin_pick))
        else $error("pin does not carry selected output");
    a_freeze_hold: assert property (
        settled && !$past(clk_en_i) |-> $stable({radio_timing_output_o,
        radio_timer_o, pin_timing_o, radio_diag_interrupt_o, irq_o}))
        else $error("outputs moved while frozen");
    a_diag_steady: assert property (
        settled && quiet_cnt >= 4'h6 |-> $stable(radio_diag_interrupt_o))
        else $error("diag interrupt moved with steady sources");
    a_irq_cause: assert property (
        settled && $rose(irq_o) |-> evt_age <= 4'h4 ||
        !$stable(radio_timing_output_o))
        else $error("irq rose without event or write");
    a_irq_drop: assert property (
        settled && $fell(irq_o) |-> $past(reg_write_i && clk_en_i) ||
        $past(reg_write_i && clk_en_i, 2))
        else $error("irq fell without write");
endmodule

bind rtoid_top rtoid_monitor u_rtoid_monitor (
    .clock_i, .reset_n_i, .clk_en_i, .reg_write_i, .reg_read_i,
    .reg_rdata_o, .tx_window_i, .rx_window_i, .mac_diag_i,
    .pin_function_id_i, .radio_timing_output_o, .radio_timer_o,
    .pin_timing_o, .radio_diag_interrupt_o, .irq_o);

//--- test/rtoid_fem_model.sv
/*
 * Front end module stand-in: counts pulses on its timing pin and keeps
 * the width of the last one. Assumes the pin is a level on our clock.
 */
module rtoid_fem_model (
    input  wire logic   clock_i,
    input  wire logic   pin_i,
    output logic [7:0]  pulses_o,
    output logic [15:0] width_o
);
    // ==========================================================
    // Pulse measurement
    logic [15:0] run = 16'h0000;

    initial pulses_o = 8'h00;
    initial width_o = 16'h0000;

    always @(posedge clock_i) begin
        if (pin_i === 1'b1) begin
            run <= run + 16'h0001;
            if (run == 16'h0000)
                pulses_o <= pulses_o + 8'h01;
        end else if (run != 16'h0000) begin
            width_o <= run;
            run <= 16'h0000;
        end
    end
endmodule

//--- test/test_rtoid_top.sv
/*
 * Self-checking bench for rtoid_top with a front end model on the pin.
 * Assumes the register map header and the bound port checker.
 */
`include "rtoid_map.vh"

module test_rtoid_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00, mac_diag_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, fem_width;
    logic reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic tx_window_i = 1'b0, rx_window_i = 1'b0;
    logic [6:0] pin_function_id_i = 7'h00;
    logic [4:0] radio_timing_output_o;
    logic [5:0] radio_timer_o;
    logic pin_timing_o, radio_diag_interrupt_o, irq_o;
    logic [7:0] fem_pulses;
    int fail_count = 0, total_checks = 0, n;

    always #25 clock_i = ~clock_i;

    rtoid_top u_rtoid_top (.clock_i, .reset_n_i, .clk_en_i, .reg_addr_i,
        .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
        .tx_window_i, .rx_window_i, .mac_diag_i, .pin_function_id_i,
        .radio_timing_output_o, .radio_timer_o, .pin_timing_o,
        .radio_diag_interrupt_o, .irq_o);
    rtoid_fem_model u_rtoid_fem_model (.clock_i, .pin_i(pin_timing_o),
        .pulses_o(fem_pulses), .width_o(fem_width));

    // ==========================================================
    // Access and check tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic in_range(input int v, input int lo, input int hi,
                            input string what);
        check({15'h0, v >= lo && v <= hi}, 16'h0001, what);
    endtask
    // Halfword accesses only; byte lanes do not exist on this port.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
                      input string what);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1;
        check(reg_rdata_o, e, what);
    endtask
    task automatic wait_out(input int i, input logic lvl, output int k);
        k = 0;
        while (radio_timing_output_o[i] !== lvl && k < 2000) begin
            @(posedge clock_i);
            #1;
            k++;
        end
    endtask
    task automatic pulse_tx(input int len);
        @(posedge clock_i);
        tx_window_i <= 1'b1;
        repeat (len) @(posedge clock_i);
        tx_window_i <= 1'b0;
        repeat (150) @(posedge clock_i);
    endtask
    task automatic settle_diag(input logic [15:0] e, input string what);
        repeat (6) @(posedge clock_i);
        #1;
        check({15'h0, radio_diag_interrupt_o}, e, what);
        @(posedge clock_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(10000 * 50);
        fail_count++;
        stop_test();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge clock_i);
        check({10'h0, radio_timer_o}, 16'h0000, "timers in reset");
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i), 16'h0000, "ctrl reset");
            wr(8'(4 * i + 1), 16'h0001);
            wr(8'(4 * i + 2), 16'h0002);
            wr(8'(4 * i), 16'h0001);
            rd(8'(4 * i + 1), 16'h0001, "on delay");
            rd(8'(4 * i + 2), 16'h0002, "off delay");
        end
        wr(8'h30, 16'hffff);
        rd(8'h30, 16'h0000, "unmapped");
        clk_en_i <= 1'b0;
        wr(8'h04, 16'h0007);
        clk_en_i <= 1'b1;
        rd(8'h04, 16'h0001, "frozen write");
        check({10'h0, radio_timer_o}, 16'h0020, "timers idle");
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            pin_function_id_i <= 7'(55 + i);
            pulse_tx(100);
            check(16'(fem_pulses), 16'(i + 1), "pin pulses");
            in_range(int'(fem_width), 95, 145, "pin width");
        end
        pin_function_id_i <= 7'(60);
        pulse_tx(100);
        check(16'(fem_pulses), 16'h0005, "pin unused id");
        $display("test pin select done");
        wr(8'h10, 16'h0003);
        wr(8'h11, 16'h0003);
        pulse_tx(100);
        check({11'h0, radio_timing_output_o}, 16'h0000, "rx only");
        @(posedge clock_i);
        rx_window_i <= 1'b1;
        wait_out(4, 1'b1, n);
        in_range(n, 41, 85, "rx on delay");
        @(posedge clock_i);
        rx_window_i <= 1'b0;
        wait_out(4, 1'b0, n);
        in_range(n, 21, 65, "rx off delay");
        $display("test window timing done");
        check({15'h0, irq_o}, 16'h0000, "irq masked");
        rd(`RTOID_OFS_STATUS, 16'h001f, "status");
        wr(`RTOID_OFS_MASK, 16'h0001);
        repeat (3) @(posedge clock_i);
        check({15'h0, irq_o}, 16'h0001, "irq unmasked");
        wr(`RTOID_OFS_STATUS, 16'h001f);
        repeat (3) @(posedge clock_i);
        check({15'h0, irq_o}, 16'h0000, "irq cleared");
        rd(`RTOID_OFS_STATUS, 16'h0000, "status cleared");
        $display("test interrupt done");
        wr(`RTOID_OFS_PAIR_A, 16'h0f03);
        wr(`RTOID_OFS_PAIR_B, 16'h1e1d);
        settle_diag(16'h0001, "diag timer 26");
        wr(`RTOID_OFS_PAIR_B, 16'h1e17);
        for (int b = 0; b < 8; b++) begin
            mac_diag_i <= 8'(1 << b);
            settle_diag((b == 3 || b == 7) ? 16'h1 : 16'h0, "diag mac");
        end
        mac_diag_i <= 8'h00;
        tx_window_i <= 1'b1;
        settle_diag(16'h0001, "diag tx window");
        tx_window_i <= 1'b0;
        rx_window_i <= 1'b1;
        settle_diag(16'h0001, "diag rx window");
        rx_window_i <= 1'b0;
        settle_diag(16'h0000, "diag quiet");
        $display("test diagnostic done");
        repeat (100) @(posedge clock_i);
        wr(8'h10, 16'h0000);
        wr(8'h00, 16'h0005);
        repeat (3) @(posedge clock_i);
        check({10'h0, radio_timer_o}, 16'h0001, "timer 26 inverse");
        rd(`RTOID_OFS_LEVEL, 16'h0001, "level inverted");
        $display("test inversion done");
        stop_test();
    end
endmodule
